//--- sfs_pkg.sv
// Purpose: shared constants and types of the supply fault supervisor
// Assumes: 10 MHz hclk, AHB-Lite register access, 32-bit words
// Notes:   offsets are byte addresses within the block's window
package sfs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int UV_DEGLITCH_NS  = 3500;
  localparam int OV_DEGLITCH_NS  = 3500;
  localparam int CP_DEGLITCH_NS  = 4000;
  localparam int AUTORESTART_MS  = 64;
  // least times round up to whole cycles
  localparam int UV_DEGLITCH_CYC =
    (UV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OV_DEGLITCH_CYC =
    (OV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CP_DEGLITCH_CYC =
    (CP_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTORESTART_CYC =
    (AUTORESTART_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          NUM_OUTPUTS        = 4;
  localparam logic [7:0]  ADDR_MODE          = 8'h00;
  localparam logic [7:0]  ADDR_OUT_CTRL      = 8'h04;
  localparam logic [7:0]  ADDR_CH_CTRL0      = 8'h08;
  localparam logic [7:0]  ADDR_QUICK_STATUS  = 8'h20;
  localparam logic [7:0]  ADDR_DEVICE_STATUS = 8'h24;
  localparam logic [7:0]  ADDR_OUT_STATE     = 8'h28;
  localparam int          MODE_FAIL_BIT      = 0;
  localparam int          CH_ON_BIT          = 0;
  localparam int          QS_PUMP_FAULT_BIT  = 0;
  localparam int          DS_LOW_BIT         = 0;
  localparam int          DS_HIGH_BIT        = 1;
  localparam int          GLOBAL_FLAG_BIT    = 7;
  localparam int          OS_PUMP_VALID_BIT  = 4;
  localparam int          OS_SETTLED_BIT     = 5;
  localparam int          OS_LOW_ACT_BIT     = 6;
  localparam int          OS_HIGH_ACT_BIT    = 7;
  localparam int          OS_PUMP_ACT_BIT    = 8;
  localparam logic        MODE_RESET         = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic supply_low;
    logic supply_high;
    logic pump_bad;
  } sfs_cmp_type;

  typedef enum logic [1:0] {
    AR_IDLE,
    AR_HOLD,
    AR_COUNT
  } sfs_restart_type;

endpackage

//--- sfs_deglitch.sv
// Purpose: deglitch filter for one comparator level
// Assumes: input synchronous to hclk
// Notes:   confirmed drops at once when the input drops
`timescale 1ns/1ps
module sfs_deglitch #(
  parameter int CYCLES = 35,
  parameter int CNT_W  = 8
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // comparator level and filtered result
  input  wire logic cond,
  output logic      confirmed
);

  logic [CNT_W-1:0] count;

  // ----------------------------------------------------------------
  // interval counter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count     <= '0;
      confirmed <= 1'b0;
    end else if (!cond) begin
      count     <= '0;
      confirmed <= 1'b0;
    end else if (count == CNT_W'(CYCLES - 1)) begin
      confirmed <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

endmodule

//--- sfs_supervisor.sv
// Purpose: supply and charge pump fault supervisor with AHB-Lite registers
// Assumes: comparator levels synchronous to hclk; zero-wait slave
// Notes:   outputs follow an undervoltage or pump fault one edge after confirmation
//
// How it works
// - Undervoltage held for its deglitch interval turns all outputs off.
// - Confirmed undervoltage sets the supply low flag and the global flag.
// - In normal mode a dropped output waits for recovery and a rewrite.
// - The supply low flag clears on a device status read after recovery.
// - In fail mode undervoltage drops are undone by autorestart.
// - Autorestart retries the faulted outputs after the 64 ms interval.
// - Confirmed overvoltage sets the supply high flag and the global flag.
// - The supply high flag clears on a device status read after recovery.
// - Until the pump first settles no output turns on; commands wait.
// - A pump out of range for its deglitch interval disables all outputs.
// - A confirmed pump failure sets the pump fault and global flags.
// - Held commands start with fresh inrush windows on pump recovery.
// - The pump fault flag clears on a quick status read after recovery.
`timescale 1ns/1ps
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int N_OUT           = NUM_OUTPUTS,
  parameter int AUTORESTART_CYC_P = AUTORESTART_CYC
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // comparator levels
  input  wire sfs_cmp_type       comparators,
  // power stage
  output logic      [N_OUT-1:0]  power_outputs,
  output logic      [N_OUT-1:0]  inrush_current_window,
  output logic                   global_device_fault_flag
);

  localparam int AR_W = $clog2(AUTORESTART_CYC_P + 1);

  logic                 uv_act;
  logic                 ov_act;
  logic                 cp_act;
  logic                 uv_act_d;
  logic                 fail_mode;
  logic                 pump_settled;
  logic                 pump_valid;
  logic                 supply_low_flag;
  logic                 supply_high_flag;
  logic                 pump_fault_flag;
  logic [N_OUT-1:0]     desired;
  logic [N_OUT-1:0]     next_desired;
  logic [N_OUT-1:0]     next_power;
  logic [N_OUT-1:0]     restart_mask;
  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic                 take;
  logic                 rd_take;
  logic [31:0]          rd_data;
  logic                 uv_rise;
  logic                 ar_fire;
  logic [AR_W-1:0]      ar_count;
  sfs_restart_type      ar_state;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic ch_hit(input logic [7:0] addr);
    ch_hit = (addr >= ADDR_CH_CTRL0) &&
             (addr < ADDR_CH_CTRL0 + 8'(4 * N_OUT)) &&
             (addr[1:0] == 2'h0);
  endfunction

  function automatic int ch_idx(input logic [7:0] addr);
    logic [7:0] rel;
    rel    = addr - ADDR_CH_CTRL0;
    ch_idx = int'(rel[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // comparator filters
  // ----------------------------------------------------------------
  sfs_deglitch #(
    .CYCLES (UV_DEGLITCH_CYC),
    .CNT_W  (8)
  ) u_uv_filter (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .cond      (comparators.supply_low),
    .confirmed (uv_act)
  );

  sfs_deglitch #(
    .CYCLES (OV_DEGLITCH_CYC),
    .CNT_W  (8)
  ) u_ov_filter (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .cond      (comparators.supply_high),
    .confirmed (ov_act)
  );

  // before first settling the pump is not a fault, just not ready
  sfs_deglitch #(
    .CYCLES (CP_DEGLITCH_CYC),
    .CNT_W  (8)
  ) u_cp_filter (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .cond      (comparators.pump_bad & pump_settled),
    .confirmed (cp_act)
  );

  assign uv_rise    = uv_act & ~uv_act_d;
  assign pump_valid = pump_settled & ~cp_act;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign take    = hsel & hready & htrans[1];
  assign rd_take = take & ~hwrite;

  always_comb begin
    rd_data = 32'h0;
    if (haddr[7:0] == ADDR_MODE) begin
      rd_data[MODE_FAIL_BIT] = fail_mode;
    end else if (haddr[7:0] == ADDR_OUT_CTRL) begin
      rd_data[N_OUT-1:0] = desired;
    end else if (ch_hit(haddr[7:0])) begin
      rd_data[CH_ON_BIT] = desired[ch_idx(haddr[7:0])];
    end else if (haddr[7:0] == ADDR_QUICK_STATUS) begin
      rd_data[QS_PUMP_FAULT_BIT] = pump_fault_flag;
      rd_data[GLOBAL_FLAG_BIT]   = global_device_fault_flag;
    end else if (haddr[7:0] == ADDR_DEVICE_STATUS) begin
      rd_data[DS_LOW_BIT]      = supply_low_flag;
      rd_data[DS_HIGH_BIT]     = supply_high_flag;
      rd_data[GLOBAL_FLAG_BIT] = global_device_fault_flag;
    end else if (haddr[7:0] == ADDR_OUT_STATE) begin
      rd_data[N_OUT-1:0]         = power_outputs;
      rd_data[OS_PUMP_VALID_BIT] = pump_valid;
      rd_data[OS_SETTLED_BIT]    = pump_settled;
      rd_data[OS_LOW_ACT_BIT]    = uv_act;
      rd_data[OS_HIGH_ACT_BIT]   = ov_act;
      rd_data[OS_PUMP_ACT_BIT]   = cp_act;
    end
  end

  // read data is sampled at the address phase so it leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= take & hwrite;
      if (take) begin
        wr_addr <= haddr[7:0];
      end
      if (rd_take) begin
        hrdata <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_mode <= MODE_RESET;
    end else if (wr_pend && wr_addr == ADDR_MODE) begin
      fail_mode <= hwdata[MODE_FAIL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // latched flags: set wins over the read clear
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_low_flag  <= 1'b0;
      supply_high_flag <= 1'b0;
    end else begin
      supply_low_flag <= uv_act |
        (supply_low_flag & ~(rd_take &
          haddr[7:0] == ADDR_DEVICE_STATUS &
          ~comparators.supply_low));
      supply_high_flag <= ov_act |
        (supply_high_flag & ~(rd_take &
          haddr[7:0] == ADDR_DEVICE_STATUS &
          ~comparators.supply_high));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_fault_flag <= 1'b0;
    end else begin
      pump_fault_flag <= cp_act |
        (pump_fault_flag & ~(rd_take &
          haddr[7:0] == ADDR_QUICK_STATUS &
          ~comparators.pump_bad));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_device_fault_flag <= 1'b0;
    end else begin
      global_device_fault_flag <= uv_act | ov_act | cp_act |
        supply_low_flag | supply_high_flag | pump_fault_flag;
    end
  end

  // ----------------------------------------------------------------
  // pump settling after power-up
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_settled <= 1'b0;
    end else if (!comparators.pump_bad) begin
      pump_settled <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // autorestart in fail mode
  // ----------------------------------------------------------------
  assign ar_fire = (ar_state == AR_COUNT) && !uv_act &&
                   (ar_count == AR_W'(AUTORESTART_CYC_P - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ar_state <= AR_IDLE;
      ar_count <= '0;
    end else if (!fail_mode) begin
      ar_state <= AR_IDLE;
      ar_count <= '0;
    end else begin
      case (ar_state)
        AR_IDLE: begin
          ar_count <= '0;
          if (uv_rise) begin
            ar_state <= AR_HOLD;
          end
        end
        AR_HOLD: begin
          ar_count <= '0;
          if (!uv_act && !comparators.supply_low) begin
            ar_state <= AR_COUNT;
          end
        end
        AR_COUNT: begin
          if (uv_act) begin
            ar_state <= AR_HOLD;
            ar_count <= '0;
          end else if (ar_fire) begin
            ar_state <= AR_IDLE;
            ar_count <= '0;
          end else begin
            ar_count <= ar_count + AR_W'(1);
          end
        end
        default: begin
          ar_state <= AR_IDLE;
          ar_count <= '0;
        end
      endcase
    end
  end

  // outputs dropped by undervoltage, kept for the retry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restart_mask <= '0;
    end else if (uv_rise) begin
      // a repeated drop during the retry must not lose the first mask
      restart_mask <= restart_mask | desired;
    end else if (ar_fire || !fail_mode) begin
      restart_mask <= '0;
    end
  end

  // ----------------------------------------------------------------
  // commanded state and power stage
  // ----------------------------------------------------------------
  always_comb begin
    next_desired = desired;
    // fail mode ignores host commands; the retry owns restart
    if (wr_pend && !fail_mode) begin
      if (wr_addr == ADDR_OUT_CTRL) begin
        next_desired = hwdata[N_OUT-1:0];
      end else if (ch_hit(wr_addr)) begin
        next_desired[ch_idx(wr_addr)] = hwdata[CH_ON_BIT];
      end
    end
    if (ar_fire) begin
      next_desired = desired | restart_mask;
    end
    if (uv_act) begin
      next_desired = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desired  <= '0;
      uv_act_d <= 1'b0;
    end else begin
      desired  <= next_desired;
      uv_act_d <= uv_act;
    end
  end

  // a held command survives pump faults and waits for recovery
  always_comb begin
    next_power = desired & {N_OUT{pump_valid & ~uv_act}};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_outputs         <= '0;
      inrush_current_window <= '0;
    end else begin
      power_outputs         <= next_power;
      inrush_current_window <= next_power & ~power_outputs;
    end
  end

endmodule

//--- sfs_supervisor_sva.sv
// Purpose: port assertions for the supply fault supervisor
// Assumes: comparator levels change only just after hclk edges
// Notes:   run counters saturate so long faults stay visible
`timescale 1ns/1ps
module sfs_supervisor_sva
  import sfs_pkg::*;
#(
  parameter int N_OUT = NUM_OUTPUTS
) (
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // observed outputs and levels
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire sfs_cmp_type      comparators,
  input wire logic [N_OUT-1:0] power_outputs,
  input wire logic [N_OUT-1:0] inrush_current_window,
  input wire logic             global_device_fault_flag
);
  logic [6:0] uv_cnt;
  logic [6:0] ov_cnt;
  logic [6:0] cp_cnt;
  logic       pump_seen;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // run lengths of each raw level; the pump level counts only after first settling
  // ------------------------------------------------------------
  function automatic logic [6:0] run(input logic [6:0] c, input logic l);
    return !l ? 7'h00 : ((c == 7'h7F) ? c : c + 7'h01);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_cnt    <= 7'h00;
      ov_cnt    <= 7'h00;
      cp_cnt    <= 7'h00;
      pump_seen <= 1'b0;
    end else begin
      uv_cnt    <= run(uv_cnt, comparators.supply_low);
      ov_cnt    <= run(ov_cnt, comparators.supply_high);
      // before first settling a bad pump is not a fault
      cp_cnt    <= run(cp_cnt, comparators.pump_bad & pump_seen);
      pump_seen <= pump_seen | ~comparators.pump_bad;
    end
  end

  chk_uv_outputs_off: assert property (
    uv_cnt >= 7'h25 |-> power_outputs == '0)
    else $error("outputs on during confirmed undervoltage");
  chk_uv_global_set: assert property (
    uv_cnt >= 7'h25 |-> global_device_fault_flag)
    else $error("global flag low during undervoltage");
  chk_ov_global_set: assert property (
    ov_cnt >= 7'h25 |-> global_device_fault_flag)
    else $error("global flag low during overvoltage");
  chk_pump_outputs_off: assert property (
    cp_cnt >= 7'h2A |-> power_outputs == '0)
    else $error("outputs on during pump failure");
  chk_pump_global_set: assert property (
    cp_cnt >= 7'h2A |-> global_device_fault_flag)
    else $error("global flag low during pump failure");
  chk_no_early_flag: assert property (
    $rose(global_device_fault_flag) |->
      ($past(uv_cnt) >= 7'h23 || $past(ov_cnt) >= 7'h23 ||
       $past(cp_cnt) >= 7'h28))
    else $error("global flag rose on a short glitch");
  chk_inrush_on_rise: assert property (
    inrush_current_window == (power_outputs & ~$past(power_outputs)))
    else $error("inrush pulse not matching turn on");
  chk_power_up_hold: assert property (
    !pump_seen |-> power_outputs == '0)
    else $error("output on before pump settled");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");

  cover property (uv_cnt == 7'h25);
  cover property (cp_cnt == 7'h2A);
  cover property (|inrush_current_window);
endmodule

bind sfs_supervisor sfs_supervisor_sva #(.N_OUT(N_OUT)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .comparators(comparators),
  .power_outputs(power_outputs),
  .inrush_current_window(inrush_current_window),
  .global_device_fault_flag(global_device_fault_flag));

//--- sfs_host_model.sv
// Purpose: host controller model on the AHB-Lite register port
// Assumes: single word transfers, slave may insert waits
// Notes:   a wait past 64 cycles raises bus_hung for the bench
`timescale 1ns/1ps
module sfs_host_model (
  // clock
  input  wire logic        hclk,
  // master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bench status
  output logic             bus_hung
);
  initial begin
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    bus_hung = 1'b0;
  end

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    // blocking so the caller sees the hang at once
    if (hready !== 1'b1) begin
      bus_hung = 1'b1;
    end
  endtask

  // address phase held until ready, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
endmodule

//--- supply_fault_supervisor_tb.sv
// Purpose: self-checking bench for the supply fault supervisor
// Assumes: autorestart shortened to 20 cycles
// Notes:   comparator bits: low 2, high 1, pump 0
`timescale 1ns/1ps
module supply_fault_supervisor_tb;
  import sfs_pkg::*;
  localparam int AR_CYC = 20;
  localparam int LOW    = 2;
  localparam int HIGH   = 1;
  localparam int PUMP   = 0;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        gflag, bus_hung;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pout, inrush;
  sfs_cmp_type cmp;
  int          fail_count, check_count;

  sfs_host_model host_u (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .bus_hung(bus_hung));
  sfs_supervisor #(.AUTORESTART_CYC_P(AR_CYC)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comparators(cmp),
    .power_outputs(pout), .inrush_current_window(inrush),
    .global_device_fault_flag(gflag));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic test_done();
    if (bus_hung === 1'b1) begin
      fail_count++;
    end
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    host_u.xfer(w, a, wd, d);
    if (bus_hung === 1'b1) begin
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check("read data", exp, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask

  // drive one comparator level, then let n edges pass
  task automatic hold(input int idx, input logic v, input int n);
    cmp[idx] <= v;
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_out(input logic [3:0] exp, input int lim);
    int n;
    n = 0;
    while (pout !== exp && n < lim) begin
      n++;
      @(posedge hclk);
    end
    check("power outputs", {28'h0, exp}, {28'h0, pout});
    if (pout !== exp) begin
      test_done();
    end
  endtask

  initial begin
    hresetn     = 1'b0;
    cmp         = 3'h1;
    fail_count  = 0;
    check_count = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADDR_MODE, 32'h0);
    rd(8'h3C, 32'h0);
    wr(ADDR_OUT_CTRL, 32'hF);
    hold(PUMP, 1'b1, 5);
    check("held", 32'h0, {28'h0, pout});
    hold(PUMP, 1'b0, 1);
    wait_out(4'hF, 10);
    hold(LOW, 1'b1, 30);
    hold(LOW, 1'b0, 2);
    rd(ADDR_DEVICE_STATUS, 32'h0);
    hold(LOW, 1'b1, 40);
    check("uv off", 32'h0, {28'h0, pout});
    rd(ADDR_DEVICE_STATUS, 32'h81);
    rd(ADDR_DEVICE_STATUS, 32'h81);
    hold(LOW, 1'b0, 3);
    rd(ADDR_DEVICE_STATUS, 32'h81);
    rd(ADDR_DEVICE_STATUS, 32'h0);
    check("no restart", 32'h0, {28'h0, pout});
    wr(ADDR_OUT_CTRL, 32'hF);
    wait_out(4'hF, 10);
    hold(HIGH, 1'b1, 40);
    rd(ADDR_DEVICE_STATUS, 32'h82);
    hold(HIGH, 1'b0, 3);
    rd(ADDR_DEVICE_STATUS, 32'h82);
    rd(ADDR_DEVICE_STATUS, 32'h0);
    hold(PUMP, 1'b1, 45);
    check("pump off", 32'h0, {28'h0, pout});
    rd(ADDR_QUICK_STATUS, 32'h81);
    wr(ADDR_OUT_CTRL, 32'h5);
    hold(PUMP, 1'b0, 1);
    wait_out(4'h5, 10);
    rd(ADDR_QUICK_STATUS, 32'h81);
    rd(ADDR_QUICK_STATUS, 32'h0);
    wr(ADDR_MODE, 32'h1);
    hold(LOW, 1'b1, 40);
    hold(LOW, 1'b0, AR_CYC - 8);
    check("retry early", 32'h0, {28'h0, pout});
    wait_out(4'h5, 20);
    wr(ADDR_OUT_CTRL, 32'hF);
    rd(ADDR_OUT_CTRL, 32'h5);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_CH_CTRL0 + 8'h04, 32'h1);
    rd(ADDR_CH_CTRL0 + 8'h04, 32'h1);
    wait_out(4'h7, 10);
    rd(ADDR_OUT_STATE, 32'h37);
    hresetn <= 1'b0;
    @(posedge hclk);
    check("reset outputs", 32'h0, {27'h0, gflag, pout});
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADDR_OUT_CTRL, 32'h0);
    rd(ADDR_MODE, 32'h0);
    test_done();
  end
endmodule
